// File: bench/rtie_event_irq_test.sv
// Self-checking testbench of the RT event interrupt block.
module rtie_event_irq_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic                     aclk;
    logic                     aresetn;
    logic [11:0]              s_axi_awaddr, s_axi_araddr;
    logic [31:0]              s_axi_wdata, s_axi_rdata;
    logic [3:0]               s_axi_wstrb;
    logic [1:0]               s_axi_bresp, s_axi_rresp;
    logic                     s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic                     s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    rtie_pkg::rtie_evt_in_t   evt_in;
    rtie_pkg::rtie_resp_out_t resp_out;
    logic                     terminal_reset_request, auto_reset_pulse, irq;
    logic [31:0]              rdat;
    logic [1:0]               resp;
    logic                     so_seen, me_seen, lw_seen, arp_seen;
    int unsigned              fail_count = 0;
    int unsigned              compares = 0;
    int unsigned              cyc = 0;

    rtie_event_irq i_rtie_event_irq (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .evt_in, .resp_out, .terminal_reset_request, .auto_reset_pulse, .irq
    );

    rtie_host_model i_rtie_host_model (
        .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );

    always #12.5 aclk = ~aclk;

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            $display("[ERR] run_time expected finished seen still running");
            fail_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (fail_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : chk

    task automatic w(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        i_rtie_host_model.wr(a, d, resp);
        chk("bresp", {30'h0, er}, {30'h0, resp});
    endtask : w

    task automatic r(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        i_rtie_host_model.rd(a, rdat, resp);
        chk("rdata", exp, rdat);
        chk("rresp", {30'h0, er}, {30'h0, resp});
    endtask : r

    // Presents one message with its completion in the same cycle, then watches the aftermath.
    task automatic msg(input logic [15:0] cw, input logic cv, il, dec, input logic [7:0] prev,
                       input logic circ, mm, mp);
        @(posedge aclk);
        evt_in <= '{cv, cw, il, dec, prev, dec, circ, circ, mm, mp, 1'b1};
        #1;
        so_seen  = resp_out.status_only;
        me_seen  = resp_out.message_error_status_flag;
        lw_seen  = 1'b0;
        arp_seen = 1'b0;
        @(posedge aclk);
        evt_in <= '0;
        repeat (4) begin
            #1;
            lw_seen  |= resp_out.log_write;
            arp_seen |= auto_reset_pulse;
            @(posedge aclk);
        end
    endtask : msg

    task automatic t_regs();
        r(12'h048, 32'h0, 2'h0);
        r(12'h024, 32'h0, 2'h0);
        w(12'h048, 32'hffff_ffff, 2'h0);
        r(12'h048, 32'h0000_01f0, 2'h0);
        w(12'h058, 32'h0000_0200, 2'h0);
        r(12'h058, 32'h0, 2'h0);
        w(12'h024, 32'h0000_ffff, 2'h0);
        r(12'h024, 32'h0, 2'h0);
        w(12'h100, 32'h0000_ffff, 2'h3);
        r(12'h100, 32'h0, 2'h3);
    endtask : t_regs

    task automatic t_illegal();
        w(12'h048, 32'h0000_0050, 2'h0);
        w(12'h058, 32'h0000_0040, 2'h0);
        msg(16'h2c61, 1'b1, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
        chk("status_only", 1'h1, so_seen);
        chk("me_flag", 1'h1, me_seen);
        chk("log_write", 1'h1, lw_seen);
        chk("log_word", 32'h0000_0050, {16'h0000, resp_out.log_word});
        chk("irq", 1'h1, irq);
        r(12'h024, 32'h0000_0050, 2'h0);
        chk("irq", 1'h0, irq);
        r(12'h024, 32'h0, 2'h0);
        msg(16'h2c61, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
        chk("status_only", 1'h0, so_seen);
        r(12'h024, 32'h0, 2'h0);
    endtask : t_illegal

    task automatic t_disabled();
        w(12'h048, 32'h0, 2'h0);
        msg(16'h2c61, 1'b1, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
        chk("log_write", 1'h0, lw_seen);
        chk("irq", 1'h0, irq);
        r(12'h024, 32'h0, 2'h0);
        msg(16'h2c08, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
        chk("reset_request", 1'h1, terminal_reset_request);
        chk("auto_pulse", 1'h0, arp_seen);
        chk("log_write", 1'h0, lw_seen);
        r(12'h024, 32'h0, 2'h0);
        w(12'h05c, 32'h0000_0002, 2'h0);
        chk("reset_request", 1'h0, terminal_reset_request);
        w(12'h05c, 32'h0000_0001, 2'h0);
        msg(16'h2c08, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
        chk("auto_pulse", 1'h1, arp_seen);
        chk("reset_request", 1'h0, terminal_reset_request);
        w(12'h05c, 32'h0, 2'h0);
    endtask : t_disabled

    task automatic t_bcast();
        w(12'h048, 32'h0000_01f0, 2'h0);
        w(12'h058, 32'h0, 2'h0);
        msg(16'hfc08, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
        chk("reset_request", 1'h1, terminal_reset_request);
        chk("irq", 1'h0, irq);
        r(12'h024, 32'h0000_0120, 2'h0);
        w(12'h05c, 32'h0000_0006, 2'h0);
        chk("reset_request", 1'h0, terminal_reset_request);
        msg(16'hfc61, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
        r(12'h024, 32'h0, 2'h0);
        msg(16'h2c08, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
        r(12'h024, 32'h0000_0100, 2'h0);
        w(12'h05c, 32'h0000_0002, 2'h0);
    endtask : t_bcast

    task automatic t_index();
        w(12'h048, 32'h0000_0090, 2'h0);
        msg(16'h0, 1'b0, 1'b0, 1'b1, 8'h01, 1'b0, 1'b0, 1'b0);
        msg(16'h0, 1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0);
        chk("log_word", 32'h0000_0090, {16'h0000, resp_out.log_word});
        r(12'h024, 32'h0000_0090, 2'h0);
        msg(16'h0, 1'b0, 1'b0, 1'b1, 8'h02, 1'b0, 1'b0, 1'b0);
        r(12'h024, 32'h0, 2'h0);
        msg(16'h0, 1'b0, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0);
        r(12'h024, 32'h0000_0080, 2'h0);
        msg(16'h0, 1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1);
        r(12'h024, 32'h0000_0010, 2'h0);
    endtask : t_index

    // An event early in a message waits for completion, then lands with the later ones.
    task automatic t_accum();
        w(12'h048, 32'h0000_0090, 2'h0);
        @(posedge aclk);
        evt_in <= '{1'b0, 16'h0000, 1'b0, 1'b1, 8'h01, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
        @(posedge aclk);
        evt_in <= '0;
        r(12'h024, 32'h0, 2'h0);
        msg(16'h0, 1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1);
        chk("log_word", 32'h0000_0090, {16'h0000, resp_out.log_word});
        r(12'h024, 32'h0000_0090, 2'h0);
    endtask : t_accum

    initial begin
        aclk    = 1'b0;
        aresetn = 1'b0;
        evt_in  = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_illegal();
        t_disabled();
        t_bcast();
        t_index();
        t_accum();
        wrap_up();
    end
endmodule : rtie_event_irq_test

// File: bench/rtie_host_model.sv
// Host processor model: AXI4-Lite master that reaches the event interrupt registers.
module rtie_host_model (
    input  wire logic        aclk,
    output logic [11:0]      s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [11:0]      s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end

    // Address and data are offered together; each is held until its own ready is sampled.
    task automatic wr(input logic [11:0] addr, input logic [31:0] data, output logic [1:0] bresp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        @(posedge aclk);
        s_axi_awaddr  <= addr;
        s_axi_wdata   <= data;
        s_axi_wstrb   <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        bresp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] addr, output logic [31:0] data, output logic [1:0] rresp);
        @(posedge aclk);
        s_axi_araddr  <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        data  = s_axi_rdata;
        rresp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : rtie_host_model

// File: hw/rtie_defines.svh
// Register offsets, field positions, reset values and widths of the RT event interrupt block.
`ifndef RTIE_DEFINES_SVH
`define RTIE_DEFINES_SVH

`define RTIE_IDX_PENDING   8'h09
`define RTIE_IDX_ENABLE    8'h12
`define RTIE_IDX_OUT_EN    8'h16
`define RTIE_IDX_CONFIG    8'h17
`define RTIE_ADDR_W        12

`define RTIE_BIT_RESET_CMD 8
`define RTIE_BIT_IDX_ZERO  7
`define RTIE_BIT_ILLEGAL   6
`define RTIE_BIT_BCAST     5
`define RTIE_BIT_MSG_ERR   4
`define RTIE_EVT_MASK      16'h01f0

`define RTIE_CFG_AUTO_RST  0
`define RTIE_CFG_RST_ACK   1
`define RTIE_CFG_BCST_INV  2
`define RTIE_CFG_MASK      16'h0005

`define RTIE_RESET_REG     16'h0000
`define RTIE_BCAST_ADDR    5'h1f
`define RTIE_MC_RESET      5'h08
`define RTIE_SA_MODE_LO    5'h00
`define RTIE_SA_MODE_HI    5'h1f
`define RTIE_IDX_ONE       8'h01

`define RTIE_RESP_OKAY     2'h0
`define RTIE_RESP_DECERR   2'h3

`endif

// File: hw/rtie_event_irq.sv
// RT event interrupt block: event capture, enable, pending, output enable and AXI4-Lite registers.

`include "rtie_defines.svh"

module rtie_event_irq (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [`RTIE_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [`RTIE_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire rtie_pkg::rtie_evt_in_t  evt_in,
    output rtie_pkg::rtie_resp_out_t     resp_out,
    output logic                         terminal_reset_request,
    output logic                         auto_reset_pulse,
    output logic                         irq
);

    function automatic logic is_bcast(input logic [15:0] w);
        return w[15:11] == `RTIE_BCAST_ADDR;
    endfunction : is_bcast

    function automatic logic is_reset_cmd(input logic [15:0] w);
        return (w[9:5] == `RTIE_SA_MODE_LO || w[9:5] == `RTIE_SA_MODE_HI)
            && w[4:0] == `RTIE_MC_RESET && w[10];
    endfunction : is_reset_cmd

    function automatic logic [7:0] word_index(input logic [`RTIE_ADDR_W-1:0] a);
        return a[9:2];
    endfunction : word_index

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    logic [15:0] pending_q, pending_d;
    logic [15:0] enable_q, enable_d;
    logic [15:0] out_en_q, out_en_d;
    logic [15:0] config_q, config_d;
    logic [15:0] acc_q, acc_d;
    logic        rst_req_q, rst_req_d;
    logic        auto_q, auto_d;
    logic        message_error_event_flag_q, message_error_event_flag_d;
    logic        log_wr_q, log_wr_d;
    logic [15:0] log_word_q, log_word_d;
    logic        bvalid_q, bvalid_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        rvalid_q, rvalid_d;
    logic [1:0]  rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;

    logic        wr_go, rd_go;
    logic [7:0]  wr_idx, rd_idx;
    logic [15:0] raw_evt, en_evt, msg_set;
    logic        reset_cmd, bcast_ok, illegal_cmd, message_error_event_now;

    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    assign s_axi_wready  = s_axi_awready;
    assign s_axi_arready = !rvalid_q;
    assign wr_go         = s_axi_awready;
    assign rd_go         = s_axi_arvalid && !rvalid_q;
    assign wr_idx        = word_index(s_axi_awaddr);
    assign rd_idx        = word_index(s_axi_araddr);

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp  = rresp_q;
    assign s_axi_rdata  = rdata_q;

    // Event decode from the protocol engine.
    always_comb begin
        reset_cmd   = evt_in.cmd_valid && is_reset_cmd(evt_in.cmd_word);
        bcast_ok    = !config_q[`RTIE_CFG_BCST_INV];
        illegal_cmd = evt_in.cmd_valid && evt_in.illegal_bit;
        message_error_event_now    = evt_in.message_error_event_manchester || evt_in.message_error_event_protocol;
        raw_evt     = `RTIE_RESET_REG;
        raw_evt[`RTIE_BIT_RESET_CMD] = reset_cmd;
        raw_evt[`RTIE_BIT_IDX_ZERO]  = (evt_in.idx_mode && evt_in.idx_dec && evt_in.idx_prev == `RTIE_IDX_ONE)
                                    || (evt_in.circ_mode && evt_in.circ_done);
        raw_evt[`RTIE_BIT_ILLEGAL]   = illegal_cmd;
        raw_evt[`RTIE_BIT_BCAST]     = evt_in.cmd_valid && bcast_ok && is_bcast(evt_in.cmd_word);
        raw_evt[`RTIE_BIT_MSG_ERR]   = message_error_event_now || illegal_cmd;
        en_evt      = raw_evt & enable_q & `RTIE_EVT_MASK;
        msg_set     = acc_q | en_evt;
    end

    // Event accumulation, pending, reset request, reply shaping and log.
    always_comb begin
        acc_d       = evt_in.msg_done ? `RTIE_RESET_REG : msg_set;
        pending_d   = pending_q;
        rst_req_d   = rst_req_q;
        auto_d      = 1'b0;
        message_error_event_flag_d = evt_in.msg_done ? 1'b0 : (message_error_event_flag_q || message_error_event_now || illegal_cmd);
        log_wr_d    = 1'b0;
        log_word_d  = log_word_q;
        if (rd_go && rd_idx == `RTIE_IDX_PENDING) begin
            pending_d = `RTIE_RESET_REG;
        end
        if (wr_go && wr_idx == `RTIE_IDX_CONFIG && s_axi_wstrb[0] && s_axi_wdata[`RTIE_CFG_RST_ACK]) begin
            rst_req_d = 1'b0;
        end
        if (rst_req_q && config_q[`RTIE_CFG_AUTO_RST]) begin
            rst_req_d = 1'b0;
            auto_d    = 1'b1;
        end
        if (reset_cmd && (!enable_q[`RTIE_BIT_RESET_CMD] || is_bcast(evt_in.cmd_word))) begin
            rst_req_d = 1'b1;
        end
        if (evt_in.msg_done && msg_set != `RTIE_RESET_REG) begin
            pending_d  = pending_d | msg_set;
            log_wr_d   = 1'b1;
            log_word_d = pending_q | msg_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_q       <= `RTIE_RESET_REG;
            pending_q   <= `RTIE_RESET_REG;
            rst_req_q   <= 1'b0;
            auto_q      <= 1'b0;
            message_error_event_flag_q <= 1'b0;
            log_wr_q    <= 1'b0;
            log_word_q  <= `RTIE_RESET_REG;
        end else begin
            acc_q       <= acc_d;
            pending_q   <= pending_d;
            rst_req_q   <= rst_req_d;
            auto_q      <= auto_d;
            message_error_event_flag_q <= message_error_event_flag_d;
            log_wr_q    <= log_wr_d;
            log_word_q  <= log_word_d;
        end
    end

    assign resp_out = '{status_only:               illegal_cmd,
                        message_error_status_flag: message_error_event_flag_q || illegal_cmd,
                        log_write:                 log_wr_q,
                        log_word:                  log_word_q};
    assign terminal_reset_request             = rst_req_q;
    assign auto_reset_pulse                   = auto_q;
    assign irq                                = |(pending_q & out_en_q);

    // Register bus: writes and reads, one of each at a time.
    always_comb begin
        enable_d = enable_q;
        out_en_d = out_en_q;
        config_d = config_q;
        bvalid_d = bvalid_q && !s_axi_bready;
        bresp_d  = bresp_q;
        rvalid_d = rvalid_q && !s_axi_rready;
        rresp_d  = rresp_q;
        rdata_d  = rdata_q;
        if (wr_go) begin
            bvalid_d = 1'b1;
            bresp_d  = `RTIE_RESP_OKAY;
            unique case (wr_idx)
                `RTIE_IDX_ENABLE: enable_d = merge16(enable_q, s_axi_wdata, s_axi_wstrb) & `RTIE_EVT_MASK;
                `RTIE_IDX_OUT_EN: out_en_d = merge16(out_en_q, s_axi_wdata, s_axi_wstrb) & `RTIE_EVT_MASK;
                `RTIE_IDX_CONFIG: config_d = merge16(config_q, s_axi_wdata, s_axi_wstrb) & `RTIE_CFG_MASK;
                `RTIE_IDX_PENDING: bresp_d = `RTIE_RESP_OKAY;
                default: bresp_d = `RTIE_RESP_DECERR;
            endcase
        end
        if (rd_go) begin
            rvalid_d = 1'b1;
            rresp_d  = `RTIE_RESP_OKAY;
            unique case (rd_idx)
                `RTIE_IDX_PENDING: rdata_d = {16'h0000, pending_q};
                `RTIE_IDX_ENABLE:  rdata_d = {16'h0000, enable_q};
                `RTIE_IDX_OUT_EN:  rdata_d = {16'h0000, out_en_q};
                `RTIE_IDX_CONFIG:  rdata_d = {16'h0000, config_q};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = `RTIE_RESP_DECERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_q <= `RTIE_RESET_REG;
            out_en_q <= `RTIE_RESET_REG;
            config_q <= `RTIE_RESET_REG;
            bvalid_q <= 1'b0;
            bresp_q  <= `RTIE_RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q  <= `RTIE_RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end else begin
            enable_q <= enable_d;
            out_en_q <= out_en_d;
            config_q <= config_d;
            bvalid_q <= bvalid_d;
            bresp_q  <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q  <= rresp_d;
            rdata_q  <= rdata_d;
        end
    end

    // Checks on the event path and the register bus.
    AST_UNUSED_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        pending_q[15:9] == 7'h00 && enable_q[15:9] == 7'h00)
        else $error("Unused or reserved bits became set.");

    AST_BIT9_READ: assert property (@(posedge aclk) disable iff (!aresetn)
        rvalid_q |-> !rdata_q[9])
        else $error("Bit 9 read back as one.");

    AST_RESET_PEND: assert property (@(posedge aclk) disable iff (!aresetn)
        (reset_cmd && enable_q[8] && evt_in.msg_done && !(rd_go && rd_idx == `RTIE_IDX_PENDING))
        |=> pending_q[8])
        else $error("Enabled reset command did not set pending bit 8.");

    AST_RESET_PIN: assert property (@(posedge aclk) disable iff (!aresetn)
        (reset_cmd && !enable_q[8]) |=> terminal_reset_request ##1 (auto_reset_pulse || !config_q[0]))
        else $error("Reset request pin or automatic reset missing.");

    AST_RST_ACK: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && wr_idx == `RTIE_IDX_CONFIG && s_axi_wstrb[0] && s_axi_wdata[`RTIE_CFG_RST_ACK] && !reset_cmd)
        |=> !terminal_reset_request)
        else $error("Host acknowledge did not release the reset request.");

    AST_DISABLED_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)
        (evt_in.msg_done && (acc_q | en_evt) == 16'h0000) |=> !log_wr_q && $stable(pending_q) || $fell(pending_q != 0))
        else $error("Disabled events touched pending or log.");

    // An index event either waits in the message accumulator or, at completion, lands in pending.
    AST_INDEX_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        (((evt_in.idx_mode && evt_in.idx_dec && evt_in.idx_prev == 8'h01) || (evt_in.circ_mode && evt_in.circ_done))
         && enable_q[7]) |=> acc_q[7] || pending_q[7])
        else $error("Index reaching zero was not captured.");

    AST_ILLEGAL_REPLY: assert property (@(posedge aclk) disable iff (!aresetn)
        illegal_cmd |-> resp_out.status_only && resp_out.message_error_status_flag
        ##1 (resp_out.message_error_status_flag || $past(evt_in.msg_done)))
        else $error("Illegal command reply is not status only with error.");

    AST_BCAST: assert property (@(posedge aclk) disable iff (!aresetn)
        (evt_in.cmd_valid && evt_in.cmd_word[15:11] == 5'h1f && config_q[2]) |-> !raw_evt[5])
        else $error("Broadcast event raised while broadcast disabled.");

    AST_BCAST_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        (evt_in.cmd_valid && is_bcast(evt_in.cmd_word) && !config_q[`RTIE_CFG_BCST_INV] && enable_q[5])
        |=> acc_q[5] || pending_q[5])
        else $error("Enabled broadcast command was not captured.");

    AST_PEND_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        (evt_in.msg_done && msg_set != 16'h0000) |=> ((pending_q & $past(msg_set)) == $past(msg_set)) && log_wr_q)
        else $error("Message events not merged into pending in one update.");

    AST_LOG_WORD: assert property (@(posedge aclk) disable iff (!aresetn)
        (evt_in.msg_done && msg_set != 16'h0000) |=> (resp_out.log_word & $past(msg_set)) == $past(msg_set))
        else $error("Log word lacks the events of the message.");

    AST_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(irq) |-> $past(evt_in.msg_done) || $past(wr_go && wr_idx == `RTIE_IDX_OUT_EN))
        else $error("Interrupt line rose without a message completion or enable write.");

    AST_IRQ_AT_DONE: assert property (@(posedge aclk) disable iff (!aresetn)
        (evt_in.msg_done && (msg_set & out_en_q) != 16'h0000 && !wr_go) |=> irq)
        else $error("Output enabled event did not raise the interrupt at completion.");

    AST_READ_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_go && rd_idx == 8'h09 && !evt_in.msg_done) |=> pending_q == 16'h0000 && rdata_q[15:0] == $past(pending_q))
        else $error("Pending read did not return then clear.");

    COV_IRQ: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
    COV_RESET_PIN: cover property (@(posedge aclk) disable iff (!aresetn) $rose(terminal_reset_request));
    COV_MULTI: cover property (@(posedge aclk) disable iff (!aresetn) evt_in.msg_done && msg_set[6] && msg_set[4]);
    COV_READ_CLR: cover property (@(posedge aclk) disable iff (!aresetn) rd_go && rd_idx == 8'h09 && pending_q != 0);

endmodule : rtie_event_irq

// File: hw/rtie_pkg.sv
// Types shared by the RT event interrupt block.
package rtie_pkg;

    // Strobes and levels from the terminal protocol engine, valid in the cycle they are high.
    typedef struct packed {
        logic        cmd_valid;
        logic [15:0] cmd_word;
        logic        illegal_bit;
        logic        idx_dec;
        logic [7:0]  idx_prev;
        logic        idx_mode;
        logic        circ_mode;
        logic        circ_done;
        logic        message_error_event_manchester;
        logic        message_error_event_protocol;
        logic        msg_done;
    } rtie_evt_in_t;

    // Reply shaping towards the transmitter and the interrupt log write port.
    typedef struct packed {
        logic        status_only;
        logic        message_error_status_flag;
        logic        log_write;
        logic [15:0] log_word;
    } rtie_resp_out_t;

endpackage : rtie_pkg
